/* File: logic/operand_address_generator.sv */
`timescale 1ns/100ps
`include "oag_consts.svh"
module operand_address_generator (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst,
    // request from sequencer and register file
    input  wire oag_pkg::ea_req_t req,
    output logic                  ready,
    // result to memory access stage
    output oag_pkg::ea_res_t      res,
    // address register write back
    output oag_pkg::wb_t          wb,
    // zero page word read for memory indirect
    output logic                  vec_rd,
    output logic      [15:0]      vec_addr,
    input  wire logic             vec_data_valid,
    input  wire logic [15:0]      vec_data
);
    import oag_pkg::*;

    // ************************************************
    // decode
    // ************************************************
    state_t      state;
    state_t      next_state;
    logic        take;
    logic        is_move;
    logic        is_bit;
    logic        is_jump;
    logic        is_word;
    logic        legal;
    logic [15:0] step;
    logic [15:0] disp_addr;
    logic [15:0] plain_addr;
    logic [15:0] rel_target;
    logic [15:0] dec_addr;
    logic [15:0] inc_value;
    logic [15:0] vec_target;
    logic [15:0] rel_offset;
    logic        align_mem;
    logic [2:0]  bit_num;

    assign take    = req.valid && ready && (state == ST_IDLE);
    assign is_move = (req.op == OP_BYTE_MOVE) || (req.op == OP_WORD_MOVE);
    assign is_bit  = (req.op == OP_BIT_REGNUM) || (req.op == OP_BIT_OTHER);
    assign is_jump = (req.op == OP_JUMP) || (req.op == OP_SUBROUTINE_CALL);

    assign is_word = (req.op == OP_WORD_MOVE) || (req.op == OP_WORD_ARITH)
                  || (req.op == OP_ADD_CONSTANT) || (req.op == OP_SUB_CONSTANT)
                  || (req.op == OP_MULDIV);

    // mode permission per instruction class
    always_comb begin
        unique case (req.mode)
            MODE_REG_DIRECT:           legal = !is_jump && (req.op != OP_BRANCH_COND)
                                            && (req.op != OP_RELATIVE_CALL);
            MODE_REG_INDIRECT:         legal = is_move || is_bit || is_jump;
            MODE_REG_INDIRECT_DISP:    legal = is_move;
            MODE_REG_INDIRECT_POSTINC: legal = is_move && !req.store;
            MODE_REG_INDIRECT_PREDEC:  legal = is_move && req.store;
            MODE_SHORT_ABSOLUTE:       legal = (req.op == OP_BYTE_MOVE) || is_bit;
            MODE_LONG_ABSOLUTE:        legal = is_move || is_jump;
            MODE_IMM_BYTE:             legal = ((req.op == OP_BYTE_MOVE)
                                            || (req.op == OP_ARITH_IMM)) && !req.store;
            MODE_IMM_WORD:             legal = (req.op == OP_WORD_MOVE) && !req.store;
            MODE_PC_RELATIVE:          legal = (req.op == OP_BRANCH_COND)
                                            || (req.op == OP_RELATIVE_CALL);
            MODE_MEM_INDIRECT:         legal = is_jump;
            default:                   legal = 1'b0;
        endcase
    end

    assign step       = is_word ? `OAG_STEP_WORD : `OAG_STEP_BYTE;
    assign align_mem  = (req.op == OP_WORD_MOVE);
    assign rel_offset = {{8{req.byte2[7]}}, req.byte2};
    assign dec_addr   = req.reg_value - step;
    assign inc_value  = req.reg_value + step;
    assign plain_addr = {req.reg_value[15:1], req.reg_value[0] & ~align_mem};
    assign vec_target = {vec_data[15:1], 1'b0};
    assign bit_num    = req.bit_from_reg ? req.bitreg_value[2:0]
                      : req.bit_in_byte4 ? req.byte4[`OAG_BITNUM_LSB +: 3]
                      : req.byte2[`OAG_BITNUM_LSB +: 3];

    ea_adder #(
        .WIDTH(16)
    ) u_disp_adder (
        .base      (req.reg_value),
        .offset    (req.ext_word),
        .align_word(align_mem),
        .sum       (disp_addr)
    );

    // pc is the address of the next instruction, giving -126..+128 from this one
    ea_adder #(
        .WIDTH(16)
    ) u_rel_adder (
        .base      (req.pc),
        .offset    (rel_offset),
        .align_word(1'b1),
        .sum       (rel_target)
    );

    // ************************************************
    // next result
    // ************************************************
    ea_res_t next_res;
    wb_t     next_wb;
    logic    next_vec_rd;

    always_comb begin
        next_res              = '0;
        next_res.word         = is_word;
        next_res.reg_field    = req.reg_field;
        next_res.bit_num      = bit_num;
        next_res.illegal      = !legal;
        next_wb               = '0;
        next_wb.reg_num       = req.reg_field[2:0];
        next_vec_rd           = 1'b0;
        if (take) begin
            next_res.valid = 1'b1;
            if (legal) begin
                unique case (req.mode)
                    MODE_REG_DIRECT: begin
                        if ((req.op == OP_ADD_CONSTANT) || (req.op == OP_SUB_CONSTANT)) begin
                            next_res.imm_valid = 1'b1;
                            next_res.imm = req.const_two ? `OAG_CONST_TWO : `OAG_CONST_ONE;
                        end
                    end
                    MODE_REG_INDIRECT: begin
                        if (is_jump) begin
                            next_res.target_valid = 1'b1;
                            next_res.target = {req.reg_value[15:1], 1'b0};
                        end else begin
                            next_res.mem_access = 1'b1;
                            next_res.addr = plain_addr;
                        end
                    end
                    MODE_REG_INDIRECT_DISP: begin
                        next_res.mem_access = 1'b1;
                        next_res.addr = disp_addr;
                    end
                    MODE_REG_INDIRECT_POSTINC: begin
                        next_res.mem_access = 1'b1;
                        next_res.addr = plain_addr;
                        next_wb.valid = 1'b1;
                        next_wb.value = inc_value;
                    end
                    MODE_REG_INDIRECT_PREDEC: begin
                        next_res.mem_access = 1'b1;
                        next_res.addr = {dec_addr[15:1], dec_addr[0] & ~align_mem};
                        next_wb.valid = 1'b1;
                        next_wb.value = dec_addr;
                    end
                    MODE_SHORT_ABSOLUTE: begin
                        next_res.mem_access = 1'b1;
                        next_res.addr = {`OAG_SHORT_ABS_PAGE, req.byte2};
                    end
                    MODE_LONG_ABSOLUTE: begin
                        if (is_jump) begin
                            next_res.target_valid = 1'b1;
                            next_res.target = {req.ext_word[15:1], 1'b0};
                        end else begin
                            next_res.mem_access = 1'b1;
                            next_res.addr = {req.ext_word[15:1], req.ext_word[0] & ~align_mem};
                        end
                    end
                    MODE_IMM_BYTE: begin
                        next_res.imm_valid = 1'b1;
                        next_res.imm = {8'h00, req.byte2};
                    end
                    MODE_IMM_WORD: begin
                        next_res.imm_valid = 1'b1;
                        next_res.imm = req.ext_word;
                    end
                    MODE_PC_RELATIVE: begin
                        next_res.target_valid = 1'b1;
                        next_res.target = rel_target;
                    end
                    MODE_MEM_INDIRECT: begin
                        next_res.valid = 1'b0;
                        next_vec_rd = 1'b1;
                    end
                    default: begin
                        next_res.illegal = 1'b1;
                    end
                endcase
            end
        end else if ((state == ST_VEC) && vec_data_valid) begin
            next_res.valid        = 1'b1;
            next_res.illegal      = 1'b0;
            next_res.word         = 1'b1;
            next_res.target_valid = 1'b1;
            next_res.target       = vec_target;
        end
    end

    always_comb begin
        unique case (state)
            ST_IDLE: next_state = next_vec_rd ? ST_VEC : ST_IDLE;
            ST_VEC:  next_state = vec_data_valid ? ST_IDLE : ST_VEC;
            default: next_state = ST_IDLE;
        endcase
    end

    // ************************************************
    // registers
    // ************************************************
    logic [15:0] vec_req_addr;
    // table read is a whole word, so the low bit is dropped too
    assign vec_req_addr = {`OAG_MEM_IND_PAGE, req.byte2[7:1], 1'b0};

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state    <= ST_IDLE;
            ready    <= 1'b1;
            res      <= '0;
            wb       <= '0;
            vec_rd   <= 1'b0;
            vec_addr <= `OAG_RESET_ADDR;
        end else begin
            state    <= next_state;
            ready    <= (next_state == ST_IDLE);
            res      <= next_res;
            wb       <= next_wb;
            vec_rd   <= next_vec_rd;
            vec_addr <= next_vec_rd ? vec_req_addr : vec_addr;
        end
    end

    // ************************************************
    // checks
    // ************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    logic        [15:0] pc_taken;
    logic signed [17:0] rel_dist;

    // pc one edge back, so the reach is measured from the taken request
    always_ff @(posedge clk_sys) begin
        pc_taken <= req.pc;
    end
    assign rel_dist = $signed({2'b00, res.target}) - $signed({2'b00, pc_taken}) + 18'sd2;

    a_postinc_wb: assert property (take && legal && req.mode == MODE_REG_INDIRECT_POSTINC
        |=> wb.valid && wb.value == $past(inc_value) && res.addr[15:1] == $past(req.reg_value[15:1]))
        else $error("post-increment write back wrong");
    a_predec_addr: assert property (take && legal && req.mode == MODE_REG_INDIRECT_PREDEC
        |=> wb.valid && res.addr[15:1] == wb.value[15:1] && wb.value == $past(req.reg_value - step))
        else $error("pre-decrement address wrong");
    a_short_page: assert property (take && legal && req.mode == MODE_SHORT_ABSOLUTE
        |=> res.mem_access && res.addr == {8'hFF, $past(req.byte2)})
        else $error("short absolute page wrong");
    a_vec_page: assert property (vec_rd |-> vec_addr[15:8] == 8'h00 && !ready)
        else $error("memory indirect address outside zero page");
    a_vec_answer: assert property (state == ST_VEC && vec_data_valid
        |=> res.valid && res.target_valid && res.target == {$past(vec_data[15:1]), 1'b0} ##1 ready)
        else $error("memory indirect target wrong");
    a_word_align: assert property (res.valid && res.mem_access && res.word && !wb.valid
        |-> !res.addr[0])
        else $error("word move address odd");
    a_target_even: assert property (res.target_valid |-> !res.target[0])
        else $error("branch target odd");
    a_illegal_quiet: assert property (take && !legal
        |=> res.illegal && !res.mem_access && !res.target_valid && !wb.valid)
        else $error("illegal mode produced an access");
    a_rel_reach: assert property (take && legal && req.mode == MODE_PC_RELATIVE
        |=> res.target_valid && rel_dist >= -18'sd126 && rel_dist <= 18'sd129)
        else $error("relative target out of reach");
    a_const_imm: assert property (take && legal && req.op == OP_ADD_CONSTANT
        |=> res.imm_valid && res.imm == ($past(req.const_two) ? 16'h0002 : 16'h0001))
        else $error("implied constant wrong");
    a_word_width: assert property (take && req.op == OP_MULDIV |=> res.word)
        else $error("multiply or divide not word width");
    a_disp_sum: assert property (take && legal && req.mode == MODE_REG_INDIRECT_DISP
        |=> res.mem_access && res.addr == ($past(req.reg_value + req.ext_word) & {15'h7FFF, ~$past(align_mem)}))
        else $error("displacement address wrong");
    a_long_abs: assert property (take && legal && req.mode == MODE_LONG_ABSOLUTE && !is_jump
        |=> res.mem_access && res.addr[15:1] == $past(req.ext_word[15:1]))
        else $error("long absolute address wrong");
    a_imm_word: assert property (take && legal && req.mode == MODE_IMM_WORD
        |=> res.imm_valid && res.imm == $past(req.ext_word))
        else $error("word immediate wrong");
    a_imm_byte: assert property (take && legal && req.mode == MODE_IMM_BYTE
        |=> res.imm_valid && res.imm == {8'h00, $past(req.byte2)})
        else $error("byte immediate wrong");
    a_bit_field: assert property (take && legal && is_bit && !req.bit_from_reg && !req.bit_in_byte4
        |=> res.bit_num == $past(req.byte2[6:4]))
        else $error("bit number field wrong");
    a_rel_target: assert property (take && legal && req.mode == MODE_PC_RELATIVE
        |=> res.target == (($past(req.pc) + {{8{$past(req.byte2[7])}}, $past(req.byte2)}) & 16'hFFFE))
        else $error("relative target wrong");
    a_direct_quiet: assert property (take && legal && req.mode == MODE_REG_DIRECT
        |=> res.valid && !res.mem_access && !res.target_valid && !wb.valid)
        else $error("register direct produced an access");
    a_vec_request: assert property (take && legal && req.mode == MODE_MEM_INDIRECT
        |=> vec_rd && !ready && !res.valid && vec_addr == {8'h00, $past(req.byte2[7:1]), 1'b0})
        else $error("memory indirect read request wrong");

    c_postinc:  cover property (take && legal && req.mode == MODE_REG_INDIRECT_POSTINC);
    c_vec_done: cover property (vec_rd ##[1:8] res.target_valid);
    c_rel:      cover property (take && legal && req.mode == MODE_PC_RELATIVE);
    c_illegal:  cover property (take && !legal);
    c_predec:   cover property (take && legal && req.mode == MODE_REG_INDIRECT_PREDEC);
endmodule

/* File: logic/oag_consts.svh */
`ifndef OAG_CONSTS_SVH
`define OAG_CONSTS_SVH

`define OAG_SHORT_ABS_PAGE 8'hFF
`define OAG_MEM_IND_PAGE   8'h00
`define OAG_STEP_BYTE      16'h0001
`define OAG_STEP_WORD      16'h0002
`define OAG_CONST_ONE      16'h0001
`define OAG_CONST_TWO      16'h0002
`define OAG_BITNUM_LSB     4
`define OAG_REL_MIN        -126
`define OAG_REL_MAX        128
`define OAG_RESET_ADDR     16'h0000

`endif

/* File: logic/oag_pkg.sv */
package oag_pkg;

    typedef enum logic [3:0] {
        MODE_REG_DIRECT          = 4'h0,
        MODE_REG_INDIRECT        = 4'h1,
        MODE_REG_INDIRECT_DISP   = 4'h2,
        MODE_REG_INDIRECT_POSTINC = 4'h3,
        MODE_REG_INDIRECT_PREDEC = 4'h4,
        MODE_SHORT_ABSOLUTE      = 4'h5,
        MODE_LONG_ABSOLUTE       = 4'h6,
        MODE_IMM_BYTE            = 4'h7,
        MODE_IMM_WORD            = 4'h8,
        MODE_PC_RELATIVE         = 4'h9,
        MODE_MEM_INDIRECT        = 4'hA
    } mode_t;

    typedef enum logic [3:0] {
        OP_BYTE_MOVE   = 4'h0,
        OP_WORD_MOVE   = 4'h1,
        OP_ARITH_IMM   = 4'h2,
        OP_ARITH_REG   = 4'h3,
        OP_WORD_ARITH  = 4'h4,
        OP_ADD_CONSTANT = 4'h5,
        OP_SUB_CONSTANT = 4'h6,
        OP_MULDIV      = 4'h7,
        OP_BIT_REGNUM  = 4'h8,
        OP_BIT_OTHER   = 4'h9,
        OP_BRANCH_COND = 4'hA,
        OP_RELATIVE_CALL = 4'hB,
        OP_JUMP        = 4'hC,
        OP_SUBROUTINE_CALL = 4'hD
    } opclass_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_VEC  = 2'b10
    } state_t;

    typedef struct packed {
        logic        valid;
        mode_t       mode;
        opclass_t    op;
        logic        store;
        logic        const_two;
        logic        bit_from_reg;
        logic        bit_in_byte4;
        logic [3:0]  reg_field;
        logic [7:0]  byte2;
        logic [7:0]  byte4;
        logic [15:0] ext_word;
        logic [15:0] reg_value;
        logic [7:0]  bitreg_value;
        logic [15:0] pc;
    } ea_req_t;

    typedef struct packed {
        logic        valid;
        logic        illegal;
        logic        mem_access;
        logic        word;
        logic [3:0]  reg_field;
        logic [15:0] addr;
        logic        imm_valid;
        logic [15:0] imm;
        logic [2:0]  bit_num;
        logic        target_valid;
        logic [15:0] target;
    } ea_res_t;

    typedef struct packed {
        logic        valid;
        logic [2:0]  reg_num;
        logic [15:0] value;
    } wb_t;

endpackage

/* File: logic/ea_adder.sv */
`timescale 1ns/100ps
module ea_adder #(
    parameter int WIDTH = 16
) (
    // operands
    input  wire logic [WIDTH-1:0] base,
    input  wire logic [WIDTH-1:0] offset,
    input  wire logic             align_word,
    // result
    output logic      [WIDTH-1:0] sum
);
    logic [WIDTH-1:0] raw;

    // carry out dropped: addresses wrap in the 64k space
    assign raw = base + offset;
    assign sum = {raw[WIDTH-1:1], raw[0] & ~align_word};
endmodule

/* File: testbench/zero_page_mem.sv */
`timescale 1ns/100ps
module zero_page_mem (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // table read request and answer delay in cycles
    input  wire logic        vec_rd,
    input  wire logic [15:0] vec_addr,
    input  wire logic [3:0]  lat,
    // answer
    output logic             vec_data_valid,
    output logic      [15:0] vec_data
);
    // ****************
    // zero page table
    // ****************
    logic [3:0]  wait_cnt;
    logic        busy;
    logic [15:0] last;

    // stored words are odd on purpose, so the target must be aligned down
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            busy <= 1'b0;
            wait_cnt <= 4'h0;
            vec_data_valid <= 1'b0;
            vec_data <= 16'h0000;
            last <= 16'h0000;
        end else begin
            vec_data_valid <= 1'b0;
            // no stale word between answers: show its inverse
            vec_data <= ~last;
            if (vec_rd) begin
                busy <= 1'b1;
                wait_cnt <= lat;
            end else if (busy && wait_cnt != 4'h0) begin
                wait_cnt <= wait_cnt - 4'h1;
            end else if (busy) begin
                busy <= 1'b0;
                vec_data_valid <= 1'b1;
                vec_data <= {8'h12, vec_addr[7:0] | 8'h01};
                last <= {8'h12, vec_addr[7:0] | 8'h01};
            end
        end
    end
endmodule

/* File: testbench/operand_address_generator_test.sv */
`timescale 1ns/100ps
module operand_address_generator_test;
    import oag_pkg::*;
    // ****************
    // signals
    // ****************
    logic        clk_sys;
    logic        rst;
    ea_req_t     req;
    logic        ready;
    ea_res_t     res;
    wb_t         wb;
    logic        vec_rd;
    logic [15:0] vec_addr;
    logic        vec_data_valid;
    logic [15:0] vec_data;
    logic [3:0]  lat;
    int          n_fail = 0;
    int          n_tests = 0;
    int          cycles = 0;

    operand_address_generator uut (
        .clk_sys        (clk_sys),
        .rst            (rst),
        .req            (req),
        .ready          (ready),
        .res            (res),
        .wb             (wb),
        .vec_rd         (vec_rd),
        .vec_addr       (vec_addr),
        .vec_data_valid (vec_data_valid),
        .vec_data       (vec_data)
    );

    zero_page_mem far_mem (
        .clk_sys        (clk_sys),
        .rst            (rst),
        .vec_rd         (vec_rd),
        .vec_addr       (vec_addr),
        .lat            (lat),
        .vec_data_valid (vec_data_valid),
        .vec_data       (vec_data)
    );

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // whole sequence needs about a hundred cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            n_fail++;
            finish_test();
        end
    end
    // ****************
    // helpers
    // ****************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic ea_req_t mk(input mode_t m, input opclass_t o, input logic [15:0] rv,
                                   input logic [7:0] b2, input logic [15:0] ext);
        ea_req_t r;
        r = '0;
        r.valid = 1'b1;
        r.mode = m;
        r.op = o;
        r.reg_field = 4'h5;
        r.reg_value = rv;
        r.byte2 = b2;
        r.ext_word = ext;
        r.byte4 = ext[7:0];
        r.pc = 16'h0102;
        return r;
    endfunction

    // present one request, let the taking edge pass, settle
    task automatic go(input ea_req_t r);
        @(posedge clk_sys);
        req <= r;
        @(posedge clk_sys);
        req <= '0;
        #1;
    endtask

    task automatic mem_ok(input logic w, input logic [15:0] a);
        check({res.valid, res.illegal, res.mem_access, res.word}, {3'b101, w});
        check(res.addr, a);
        check(res.reg_field, 4'h5);
    endtask

    task automatic refused;
        check({res.valid, res.illegal, res.mem_access, res.imm_valid, res.target_valid, wb.valid}, 6'b110000);
    endtask

    task automatic finish_test;
        if (n_fail == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // ****************
    // scenarios
    // ****************
    task automatic t_direct;
        opclass_t w[5] = '{OP_WORD_MOVE, OP_WORD_ARITH, OP_ADD_CONSTANT, OP_SUB_CONSTANT, OP_MULDIV};
        foreach (w[i]) begin
            go(mk(MODE_REG_DIRECT, w[i], 16'h0000, 8'h00, 16'h0000));
            check({res.valid, res.illegal, res.mem_access, res.word}, 4'b1001);
        end
        go(mk(MODE_REG_DIRECT, OP_ARITH_REG, 16'h0000, 8'h00, 16'h0000));
        check({res.valid, res.illegal, res.mem_access, res.word}, 4'b1000);
        go(mk(MODE_IMM_BYTE, OP_ARITH_IMM, 16'h0000, 8'h5A, 16'h0000));
        check({res.valid, res.illegal, res.imm_valid, res.imm}, {3'b101, 16'h005A});
        go(mk(MODE_REG_INDIRECT, OP_ARITH_REG, 16'h1000, 8'h00, 16'h0000));
        refused();
    endtask

    task automatic t_modes;
        go(mk(MODE_REG_INDIRECT, OP_BYTE_MOVE, 16'h3457, 8'h00, 16'h0000));
        mem_ok(1'b0, 16'h3457);
        go(mk(MODE_REG_INDIRECT_DISP, OP_WORD_MOVE, 16'h1000, 8'h00, 16'h0235));
        mem_ok(1'b1, 16'h1234);
        go(mk(MODE_REG_INDIRECT_DISP, OP_ARITH_IMM, 16'h1000, 8'h00, 16'h0235));
        refused();
        go(mk(MODE_SHORT_ABSOLUTE, OP_BYTE_MOVE, 16'h0000, 8'h9C, 16'h0000));
        mem_ok(1'b0, 16'hFF9C);
        go(mk(MODE_LONG_ABSOLUTE, OP_WORD_MOVE, 16'h0000, 8'h00, 16'h4567));
        mem_ok(1'b1, 16'h4566);
        go(mk(MODE_LONG_ABSOLUTE, OP_ARITH_REG, 16'h0000, 8'h00, 16'h4567));
        refused();
        go(mk(MODE_PC_RELATIVE, OP_BYTE_MOVE, 16'h0000, 8'h10, 16'h0000));
        refused();
        go(mk(MODE_MEM_INDIRECT, OP_WORD_MOVE, 16'h0000, 8'h20, 16'h0000));
        check({vec_rd, ready}, 2'b01);
        refused();
    endtask

    task automatic t_step;
        ea_req_t r;
        go(mk(MODE_REG_INDIRECT_POSTINC, OP_WORD_MOVE, 16'h1000, 8'h00, 16'h0000));
        mem_ok(1'b1, 16'h1000);
        check({wb.valid, wb.reg_num, wb.value}, {4'hD, 16'h1002});
        go(mk(MODE_REG_INDIRECT_POSTINC, OP_BYTE_MOVE, 16'h2001, 8'h00, 16'h0000));
        mem_ok(1'b0, 16'h2001);
        check({wb.valid, wb.value}, {1'b1, 16'h2002});
        r = mk(MODE_REG_INDIRECT_PREDEC, OP_WORD_MOVE, 16'h1000, 8'h00, 16'h0000);
        r.store = 1'b1;
        go(r);
        mem_ok(1'b1, 16'h0FFE);
        check({wb.valid, wb.value}, {1'b1, 16'h0FFE});
        r.op = OP_BYTE_MOVE;
        go(r);
        mem_ok(1'b0, 16'h0FFF);
        check({wb.valid, wb.value}, {1'b1, 16'h0FFF});
        r.mode = MODE_REG_INDIRECT_POSTINC;
        go(r);
        refused();
    endtask

    task automatic t_imm;
        ea_req_t r;
        go(mk(MODE_IMM_WORD, OP_WORD_MOVE, 16'h0000, 8'h00, 16'hBEEF));
        check({res.valid, res.illegal, res.imm_valid, res.imm}, {3'b101, 16'hBEEF});
        go(mk(MODE_IMM_WORD, OP_BYTE_MOVE, 16'h0000, 8'h00, 16'hBEEF));
        refused();
        for (int i = 0; i < 4; i++) begin
            r = mk(MODE_REG_DIRECT, i[1] ? OP_SUB_CONSTANT : OP_ADD_CONSTANT, 16'h0000, 8'h00, 16'h0000);
            r.const_two = i[0];
            go(r);
            check({res.imm_valid, res.imm}, {1'b1, 16'h0001 + 16'(i[0])});
        end
    endtask

    task automatic t_bits;
        ea_req_t r;
        go(mk(MODE_REG_INDIRECT, OP_BIT_OTHER, 16'h0040, 8'h50, 16'h0000));
        mem_ok(1'b0, 16'h0040);
        check(res.bit_num, 3'd5);
        r = mk(MODE_SHORT_ABSOLUTE, OP_BIT_OTHER, 16'h0000, 8'h70, 16'h0020);
        r.bit_in_byte4 = 1'b1;
        go(r);
        mem_ok(1'b0, 16'hFF70);
        check(res.bit_num, 3'd2);
        r = mk(MODE_REG_DIRECT, OP_BIT_REGNUM, 16'h0000, 8'h00, 16'h0000);
        r.bit_from_reg = 1'b1;
        r.bitreg_value = 8'hFE;
        go(r);
        check({res.valid, res.illegal, res.bit_num}, 5'b10110);
        go(mk(MODE_REG_INDIRECT_DISP, OP_BIT_OTHER, 16'h0040, 8'h50, 16'h0000));
        refused();
    endtask

    task automatic t_branch;
        logic [7:0]  d[3] = '{8'hFE, 8'h7F, 8'h80};
        logic [15:0] t[3] = '{16'h0100, 16'h0180, 16'h0082};
        for (int i = 0; i < 3; i++) begin
            go(mk(MODE_PC_RELATIVE, i == 1 ? OP_RELATIVE_CALL : OP_BRANCH_COND, 16'h0000, d[i], 16'h0000));
            check({res.valid, res.illegal, res.target_valid, res.target}, {3'b101, t[i]});
        end
    endtask

    // table read; the far side answers after l idle cycles
    task automatic t_indirect(input opclass_t o, input logic [3:0] l);
        int n;
        lat <= l;
        go(mk(MODE_MEM_INDIRECT, o, 16'h0000, 8'h21, 16'h0000));
        check({vec_rd, vec_addr, ready, res.valid}, {1'b1, 16'h0020, 2'b00});
        n = 0;
        while (res.valid !== 1'b1 && n < 20) begin
            check(ready, 1'b0);
            @(posedge clk_sys);
            #1;
            n++;
        end
        check({res.valid, res.illegal, res.target_valid, res.target, ready}, {3'b101, 16'h1220, 1'b1});
    endtask

    initial begin
        rst = 1'b1;
        req = '0;
        lat = 4'h0;
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        t_direct();
        t_modes();
        t_step();
        t_imm();
        t_bits();
        t_branch();
        t_indirect(OP_JUMP, 4'h0);
        t_indirect(OP_SUBROUTINE_CALL, 4'h5);
        finish_test();
    end
endmodule
